// ==== verilog/frs_ramp_map.vh ====
// constants for the fmcw ramp sequencer: register indices, field positions,
// reset values and ramp type codes.
// assumes one 100 MHz phase-detector-rate clock and a plain register port.
`ifndef FRS_RAMP_MAP_VH
`define FRS_RAMP_MAP_VH

// ****************************************************************
// register indices
// ****************************************************************
`define FRS_IDX_START 4'h0
`define FRS_IDX_FINE 4'h1
`define FRS_IDX_REFDIV 4'h2
`define FRS_IDX_FUNC 4'h3
`define FRS_IDX_TIMER 4'h4
`define FRS_IDX_DEV 4'h5
`define FRS_IDX_STEP 4'h6
`define FRS_IDX_DELAY 4'h7
`define FRS_IDX_STATUS 4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define FRS_START_BIT 31
`define FRS_INT_MSB 26
`define FRS_INT_LSB 15
`define FRS_FRACHI_MSB 14
`define FRS_FRACHI_LSB 3
`define FRS_FRACLO_MSB 15
`define FRS_FRACLO_LSB 3
`define FRS_FIRST_TIMER_DIVIDER_MSB 14
`define FRS_FIRST_TIMER_DIVIDER_LSB 3
`define FRS_TYPE_MSB 11
`define FRS_TYPE_LSB 10
`define FRS_SECOND_TIMER_DIVIDER_MSB 18
`define FRS_SECOND_TIMER_DIVIDER_LSB 7
`define FRS_DIVMODE_MSB 20
`define FRS_DIVMODE_LSB 19
`define FRS_DEVW_MSB 18
`define FRS_DEVW_LSB 3
`define FRS_SHIFT_MSB 22
`define FRS_SHIFT_LSB 19
`define FRS_SETSEL_BIT 23
`define FRS_DUAL_BIT 24
`define FRS_FSK_BIT 25
`define FRS_STEPS_MSB 22
`define FRS_STEPS_LSB 3
`define FRS_DLYW_MSB 14
`define FRS_DLYW_LSB 3
`define FRS_DLYSTART_BIT 15
`define FRS_DLYCLK_BIT 16
`define FRS_DLYGAP_BIT 17
`define FRS_FASTLOCK_BIT 18

// ****************************************************************
// values
// ****************************************************************
`define FRS_REG_RESET 32'h0000_0000
`define FRS_DIVMODE_RAMP 2'h3
`define FRS_TYPE_SAW 2'h0
`define FRS_TYPE_TRI 2'h1
`define FRS_TYPE_SAW_ONCE 2'h2
`define FRS_TYPE_RAMP_ONCE 2'h3
`define FRS_DEVIATION_WORD_MAX 17'h0_8000
`define FRS_FRAC_BITS 25
`define FRS_INT_HEADROOM 13'h100

`endif

// ==== verilog/frs_tick_timer.v ====
// two-stage interval timer: one tick every div_a * div_b enabled cycles.
// assumes the enable drops whenever the interval must restart.
`timescale 1ns/1ps
module frs_tick_timer (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire en,
    input wire [11:0] div_a,
    input wire [11:0] div_b,
    // event
    output wire tick
);

    reg [11:0] cnt_a_q;
    reg [11:0] cnt_b_q;
    wire [11:0] lim_a;
    wire [11:0] lim_b;
    wire wrap_a;
    wire wrap_b;

    // a zero divider behaves as one
    assign lim_a = (div_a == 12'h000) ? 12'h001 : div_a;
    assign lim_b = (div_b == 12'h000) ? 12'h001 : div_b;
    assign wrap_a = (cnt_a_q >= lim_a);
    assign wrap_b = (cnt_b_q >= lim_b);
    assign tick = en & wrap_a & wrap_b;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_a_q <= 12'h001;
            cnt_b_q <= 12'h001;
        end else if (!en) begin
            cnt_a_q <= 12'h001;
            cnt_b_q <= 12'h001;
        end else if (wrap_a) begin
            cnt_a_q <= 12'h001;
            cnt_b_q <= wrap_b ? 12'h001 : cnt_b_q + 12'h001;
        end else begin
            cnt_a_q <= cnt_a_q + 12'h001;
        end
    end

endmodule

// ==== verilog/frs_ramp_sequencer.v ====
// fmcw ramp sequencer: holds the configuration registers and steps the
// divider value for the fractional-n modulator at each timer interval.
// assumes REF_CLK is the phase-detector-rate clock and FSK_DATA is async.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "frs_ramp_map.vh"
module frs_ramp_sequencer (
    // clock and reset
    input wire REF_CLK,
    input wire RST,
    // register port
    input wire [3:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // modulation pin
    input wire FSK_DATA,
    // divider side
    output reg [11:0] DIV_INT,
    output reg [24:0] DIV_FRAC,
    output reg FAST_LOCK,
    output reg RAMP_BUSY
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_WAIT = 5'h02;
    localparam [4:0] ST_RAMP = 5'h04;
    localparam [4:0] ST_GAP = 5'h08;
    localparam [4:0] ST_HOLD = 5'h10;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    reg [31:0] start_q;
    reg [31:0] fine_q;
    reg [31:0] refdiv_q;
    reg [31:0] func_q;
    reg [31:0] timer_q;
    reg [31:0] dev_q;
    reg [31:0] step_q;
    reg [31:0] delay_q;
    reg [15:0] devw_q [0:1];
    reg [3:0] shift_q [0:1];
    reg [19:0] steps_q [0:1];
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg set_q;
    reg dir_q;
    reg gap_seen_q;
    reg [19:0] cnt_q;
    reg [37:0] offs_q;
    reg [2:0] fsk_sync_q;

    wire start_wr;
    wire [1:0] ramp_type;
    wire dual_en;
    wire fsk_en;
    wire [11:0] first_timer_divider;
    wire [11:0] second_timer_divider_use;
    wire [11:0] dly_div;
    wire step_tick;
    wire dly_tick;
    wire ramp_set;
    wire [37:0] step_amt;
    wire [37:0] fsk_amt;
    wire [37:0] base;
    wire [37:0] nval;
    wire done;
    wire gap_en;

    assign start_wr = WR && (ADDR == `FRS_IDX_START);
    assign ramp_type = func_q[`FRS_TYPE_MSB:`FRS_TYPE_LSB];
    assign dual_en = dev_q[`FRS_DUAL_BIT];
    assign fsk_en = dev_q[`FRS_FSK_BIT];
    assign first_timer_divider = refdiv_q[`FRS_FIRST_TIMER_DIVIDER_MSB:`FRS_FIRST_TIMER_DIVIDER_LSB];
    // second divider only counts in ramp divider mode
    assign second_timer_divider_use = (timer_q[`FRS_DIVMODE_MSB:`FRS_DIVMODE_LSB] ==
        `FRS_DIVMODE_RAMP) ? timer_q[`FRS_SECOND_TIMER_DIVIDER_MSB:`FRS_SECOND_TIMER_DIVIDER_LSB] :
        12'h001;
    assign dly_div = delay_q[`FRS_DLYCLK_BIT] ? first_timer_divider : 12'h001;
    assign gap_en = delay_q[`FRS_DLYGAP_BIT];
    // with fsk on the ramp the second set is the hop, not a ramp rate
    assign ramp_set = (dual_en && !fsk_en) ? set_q : 1'b0;

    // ****************************************************************
    // step size and divider value
    // ****************************************************************
    // signed deviation word shifted by the exponent, in 2^-25 units
    assign step_amt = {{22{devw_q[ramp_set][15]}}, devw_q[ramp_set]}
        << shift_q[ramp_set];
    assign fsk_amt = (fsk_en && fsk_sync_q[2]) ?
        ({{22{devw_q[1][15]}}, devw_q[1]} << shift_q[1]) :
        38'h0;
    assign base = {1'b0, start_q[`FRS_INT_MSB:`FRS_INT_LSB],
        start_q[`FRS_FRACHI_MSB:`FRS_FRACHI_LSB],
        fine_q[`FRS_FRACLO_MSB:`FRS_FRACLO_LSB]};
    assign nval = base + offs_q + fsk_amt;
    assign done = (cnt_q >= steps_q[ramp_set]);

    // ****************************************************************
    // timers
    // ****************************************************************
    frs_tick_timer u_step_timer (
        .clk(REF_CLK),
        .rst(RST),
        .en(state_q == ST_RAMP),
        .div_a(first_timer_divider),
        .div_b(second_timer_divider_use),
        .tick(step_tick)
    );

    frs_tick_timer u_delay_timer (
        .clk(REF_CLK),
        .rst(RST),
        .en((state_q == ST_WAIT) || (state_q == ST_GAP)),
        .div_a(dly_div),
        .div_b(delay_q[`FRS_DLYW_MSB:`FRS_DLYW_LSB]),
        .tick(dly_tick)
    );

    // ****************************************************************
    // register writes and reads
    // ****************************************************************
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            start_q <= `FRS_REG_RESET;
            fine_q <= `FRS_REG_RESET;
            refdiv_q <= `FRS_REG_RESET;
            func_q <= `FRS_REG_RESET;
            timer_q <= `FRS_REG_RESET;
            dev_q <= `FRS_REG_RESET;
            step_q <= `FRS_REG_RESET;
            delay_q <= `FRS_REG_RESET;
            devw_q[0] <= 16'h0000;
            devw_q[1] <= 16'h0000;
            shift_q[0] <= 4'h0;
            shift_q[1] <= 4'h0;
            steps_q[0] <= 20'h00000;
            steps_q[1] <= 20'h00000;
        end else if (WR) begin
            case (ADDR)
                `FRS_IDX_START: start_q <= WDATA;
                `FRS_IDX_FINE: fine_q <= WDATA;
                `FRS_IDX_REFDIV: refdiv_q <= WDATA;
                `FRS_IDX_FUNC: func_q <= WDATA;
                `FRS_IDX_TIMER: timer_q <= WDATA;
                `FRS_IDX_DEV: begin
                    dev_q <= WDATA;
                    // only the selected set changes
                    devw_q[WDATA[`FRS_SETSEL_BIT]] <=
                        WDATA[`FRS_DEVW_MSB:`FRS_DEVW_LSB];
                    shift_q[WDATA[`FRS_SETSEL_BIT]] <=
                        WDATA[`FRS_SHIFT_MSB:`FRS_SHIFT_LSB];
                end
                `FRS_IDX_STEP: begin
                    step_q <= WDATA;
                    steps_q[WDATA[`FRS_SETSEL_BIT]] <=
                        WDATA[`FRS_STEPS_MSB:`FRS_STEPS_LSB];
                end
                `FRS_IDX_DELAY: delay_q <= WDATA;
                default: ;
            endcase
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `FRS_IDX_START: RDATA <= start_q;
                `FRS_IDX_FINE: RDATA <= fine_q;
                `FRS_IDX_REFDIV: RDATA <= refdiv_q;
                `FRS_IDX_FUNC: RDATA <= func_q;
                `FRS_IDX_TIMER: RDATA <= timer_q;
                `FRS_IDX_DEV: RDATA <= dev_q;
                `FRS_IDX_STEP: RDATA <= step_q;
                `FRS_IDX_DELAY: RDATA <= delay_q;
                `FRS_IDX_STATUS:
                    RDATA <= {3'h0, state_q, 2'h0, set_q, dir_q, cnt_q};
                default: RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // fsk pin synchroniser
    // ****************************************************************
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            fsk_sync_q <= 3'h0;
        end else begin
            fsk_sync_q <= {fsk_sync_q[1:0], FSK_DATA};
        end
    end

    // ****************************************************************
    // sequencer state
    // ****************************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = ST_IDLE;
            ST_WAIT: if (dly_tick) state_d = ST_RAMP;
            ST_RAMP: begin
                if (step_tick && done) begin
                    if (ramp_type == `FRS_TYPE_SAW_ONCE ||
                        ramp_type == `FRS_TYPE_RAMP_ONCE) begin
                        state_d = ST_HOLD;
                    end else if (gap_en && (ramp_type == `FRS_TYPE_SAW ||
                        dir_q)) begin
                        state_d = ST_GAP;
                    end
                end
            end
            ST_GAP: if (dly_tick) state_d = ST_RAMP;
            ST_HOLD: state_d = ST_HOLD;
            default: state_d = ST_IDLE;
        endcase
        if (start_wr) begin
            if (!WDATA[`FRS_START_BIT]) begin
                state_d = ST_IDLE;
            end else if (delay_q[`FRS_DLYSTART_BIT]) begin
                state_d = ST_WAIT;
            end else begin
                state_d = ST_RAMP;
            end
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            set_q <= 1'b0;
            dir_q <= 1'b0;
            cnt_q <= 20'h00000;
            offs_q <= 38'h0;
            gap_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start_wr) begin
                // a new start or a stop clears the sweep
                set_q <= 1'b0;
                dir_q <= 1'b0;
                cnt_q <= 20'h00000;
                offs_q <= 38'h0;
                gap_seen_q <= 1'b0;
            end else if (state_q == ST_GAP && dly_tick) begin
                gap_seen_q <= 1'b1;
            end else if (state_q == ST_RAMP && step_tick) begin
                if (!done) begin
                    cnt_q <= cnt_q + 20'h00001;
                    offs_q <= dir_q ? offs_q - step_amt :
                        offs_q + step_amt;
                end else begin
                    case (ramp_type)
                        `FRS_TYPE_SAW, `FRS_TYPE_SAW_ONCE: begin
                            offs_q <= 38'h0;
                            cnt_q <= 20'h00000;
                            set_q <= ~set_q;
                        end
                        `FRS_TYPE_TRI: begin
                            // turn round; the full cycle takes two sweeps
                            dir_q <= ~dir_q;
                            if (dir_q && gap_en) begin
                                cnt_q <= 20'h00000;
                            end else begin
                                cnt_q <= 20'h00001;
                                offs_q <= dir_q ? offs_q + step_amt :
                                    offs_q - step_amt;
                            end
                            if (dir_q) begin
                                set_q <= ~set_q;
                            end
                        end
                        `FRS_TYPE_RAMP_ONCE: cnt_q <= cnt_q;
                        default: cnt_q <= 20'h00000;
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            DIV_INT <= 12'h000;
            DIV_FRAC <= 25'h0000000;
            FAST_LOCK <= 1'b0;
            RAMP_BUSY <= 1'b0;
        end else begin
            DIV_INT <= nval[36:25];
            DIV_FRAC <= nval[24:0];
            // wide bandwidth while the first between-ramp delay runs
            FAST_LOCK <= delay_q[`FRS_FASTLOCK_BIT] && !gap_seen_q &&
                (state_d == ST_GAP) && !start_wr;
            RAMP_BUSY <= (state_d != ST_IDLE);
        end
    end

endmodule

// ==== verification/frs_seq_properties.sv ====
// port checker for the ramp sequencer
// assumes it is bound to frs_ramp_sequencer and sees only its ports
`timescale 1ns/1ps
module frs_seq_props (
    // clock and reset
    input wire REF_CLK,
    input wire RST,
    // register port
    input wire [3:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    // pins
    input wire FSK_DATA,
    input wire [11:0] DIV_INT,
    input wire [24:0] DIV_FRAC,
    input wire FAST_LOCK,
    input wire RAMP_BUSY
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire go = WR && ADDR == 4'h0;
    // ****
    // properties
    // ****
    start_busy_a:
        assert property (go && WDATA[31] |=> ##[0:1] RAMP_BUSY)
        else $error("start write did not make the sequencer busy");
    idle_hold_a:
        assert property (!RAMP_BUSY && !(go && WDATA[31]) |=> !RAMP_BUSY)
        else $error("sequencer left idle without a start");
    stop_idle_a:
        assert property (go && !WDATA[31] |=> ##[0:1] !RAMP_BUSY)
        else $error("stop write did not return to idle");
    lock_busy_a:
        assert property (FAST_LOCK |-> RAMP_BUSY)
        else $error("fast lock while idle");
    lock_still_a:
        assert property (FAST_LOCK [*4] |-> $stable({DIV_INT, DIV_FRAC}))
        else $error("divider moved during the gap");
    unmapped_zero_a:
        assert property (RD && ADDR > 4'h8 |=> RDATA == 32'h0)
        else $error("unmapped index read not zero");
    status_onehot_a:
        assert property (RD && ADDR == 4'h8 |=> $onehot(RDATA[28:24]))
        else $error("status state not one-hot");
    rdata_quiet_a:
        assert property (!RD |=> RDATA == 32'h0)
        else $error("read data without a read");
endmodule

bind frs_ramp_sequencer frs_seq_props i_props (
    .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .FSK_DATA(FSK_DATA), .DIV_INT(DIV_INT),
    .DIV_FRAC(DIV_FRAC), .FAST_LOCK(FAST_LOCK), .RAMP_BUSY(RAMP_BUSY)
);

// ==== verification/frs_divider_model.sv ====
// divider and modulator stand-in: latches the n value and counts hops
// assumes the clock of the sequencer
`timescale 1ns/1ps
module frs_divider_model (
    // clock and reset
    input wire clk,
    input wire rst,
    // divider value
    input wire [11:0] div_int,
    input wire [24:0] div_frac,
    // observed
    output reg [36:0] n_q,
    output reg [15:0] hops_q
);
    // n in units of one fraction step
    wire [36:0] n_d = {div_int, div_frac};
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            n_q <= 37'h0;
            hops_q <= 16'h0;
        end else begin
            n_q <= n_d;
            if (n_d != n_q) begin
                hops_q <= hops_q + 16'h1;
            end
        end
    end
endmodule

// ==== verification/frs_ramp_sequencer_tb.sv ====
// self-checking bench for the ramp sequencer
// assumes the divider model and the bound checker are compiled first
`timescale 1ns/1ps
`define FRS_CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    err_count++; $display("BAD t=%0t got %h exp %h", $time, (a), (b)); \
    end end
module frs_ramp_sequencer_tb;
    localparam [36:0] BASE = {12'h00a, 25'h0};
    localparam [31:0] BW = 32'h0005_0000;
    reg REF_CLK = 1'b0;
    reg RST = 1'b1;
    reg WR = 1'b0;
    reg RD = 1'b0;
    reg FSK_DATA = 1'b0;
    reg [3:0] ADDR = 4'h0;
    reg [31:0] WDATA = 32'h0;
    wire [31:0] RDATA;
    wire [11:0] DIV_INT;
    wire [24:0] DIV_FRAC;
    wire FAST_LOCK;
    wire RAMP_BUSY;
    wire [36:0] n;
    wire [15:0] hops;
    int err_count = 0;
    int cmp_count = 0;
    int cyc, fl, i;
    always #5 REF_CLK = ~REF_CLK;
    frs_ramp_sequencer i_dut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FSK_DATA(FSK_DATA),
        .DIV_INT(DIV_INT), .DIV_FRAC(DIV_FRAC), .FAST_LOCK(FAST_LOCK),
        .RAMP_BUSY(RAMP_BUSY));
    frs_divider_model i_model (.clk(REF_CLK), .rst(RST), .div_int(DIV_INT),
        .div_frac(DIV_FRAC), .n_q(n), .hops_q(hops));
    // ****
    // word builders and bus tasks
    // ****
    function [31:0] f_dev(input [2:0] f, input [3:0] sh, input [15:0] w);
        f_dev = {6'h0, f, sh, w, 3'h0};
    endfunction
    function [31:0] f_stp(input s, input [19:0] c);
        f_stp = {8'h0, s, c, 3'h0};
    endfunction
    function [31:0] f_tmr(input [1:0] m, input [11:0] c2);
        f_tmr = {11'h0, m, c2, 7'h0};
    endfunction
    function [31:0] f_dly(input fk, gp, ck, sd, input [11:0] w);
        f_dly = {13'h0, fk, gp, ck, sd, w, 3'h0};
    endfunction
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input [3:0] a, input [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input [3:0] a, input [31:0] e);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1;
        `FRS_CHK(RDATA, e)
    endtask
    task automatic hop();
        int h;
        h = hops;
        cyc = 0;
        fl = 0;
        while (hops == h) begin
            @(posedge REF_CLK);
            #1;
            cyc++;
            if (FAST_LOCK === 1'b1) fl++;
            if (cyc > 6000) begin
                err_count++;
                complete_run();
            end
        end
    endtask
    task automatic nxt(input [36:0] k, input int iv);
        hop();
        `FRS_CHK(n, BASE + k)
        `FRS_CHK(n[36:25] <= BASE[36:25] + 12'h100, 1'b1)
        if (iv > 0) `FRS_CHK(cyc, iv)
    endtask
    task automatic cfg(input [31:0] dl, s0, s1, d0, d1, tr, fn, c1);
        wr(4'h7, dl);
        wr(4'h6, s0);
        wr(4'h6, s1);
        wr(4'h5, d0);
        wr(4'h5, d1);
        wr(4'h4, tr);
        wr(4'h3, fn);
        wr(4'h2, c1 << 3);
        wr(4'h1, 32'h0);
        wr(4'h0, BW | 32'h8000_0000);
    endtask
    task automatic stop(input string nm);
        wr(4'h0, BW);
        repeat (4) @(posedge REF_CLK);
        #1;
        `FRS_CHK(RAMP_BUSY, 1'b0)
        `FRS_CHK(n, BASE)
        $display("test %s done at %0t", nm, $time);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        `FRS_CHK(DIV_INT, 12'h0)
        `FRS_CHK(FAST_LOCK, 1'b0)
        for (i = 0; i < 8; i++) rd(i[3:0], 32'h0);
        rd(4'h8, 32'h0100_0000);
        wr(4'h5, f_dev(3'h3, 4'h9, 16'h8000));
        rd(4'h5, f_dev(3'h3, 4'h9, 16'h8000));
        wr(4'h9, 32'hffff_ffff);
        rd(4'h9, 32'h0);
        stop("reset");
    endtask
    task automatic t_saw();
        for (i = 0; i < 2; i++) begin
            cfg(0, f_stp(0, 2), f_stp(0, 2), f_dev(0, 3, 2), f_dev(0, 3, 2),
                f_tmr(i ? 2'h3 : 2'h0, 5), 0, 3);
            nxt(16, 0);
            nxt(32, i ? 15 : 3);
            nxt(0, i ? 15 : 3);
            nxt(16, i ? 15 : 3);
            stop("sawtooth");
        end
    endtask
    task automatic t_tri();
        cfg(0, f_stp(0, 2), f_stp(0, 2), f_dev(0, 0, 1), f_dev(0, 0, 1),
            f_tmr(0, 1), 32'h400, 2);
        nxt(1, 0);
        nxt(2, 2);
        nxt(1, 2);
        nxt(0, 2);
        nxt(1, 2);
        stop("triangle");
    endtask
    task automatic t_dual();
        cfg(0, f_stp(0, 2), f_stp(1, 1), f_dev(2, 0, 1), f_dev(3, 0, 8),
            f_tmr(0, 1), 0, 6);
        nxt(1, 0);
        wr(4'h5, f_dev(3, 0, 4));
        nxt(2, 0);
        nxt(0, 6);
        nxt(4, 6);
        nxt(0, 6);
        nxt(1, 6);
        stop("dual");
    endtask
    task automatic t_gap();
        cfg(f_dly(1, 1, 0, 0, 20), f_stp(0, 1), f_stp(1, 1), f_dev(2, 0, 1),
            f_dev(3, 0, 2), f_tmr(0, 1), 0, 3);
        nxt(1, 0);
        nxt(0, 0);
        nxt(2, 0);
        `FRS_CHK(cyc >= 20 && cyc <= 28, 1'b1)
        `FRS_CHK(fl > 0, 1'b1)
        nxt(0, 0);
        nxt(1, 0);
        `FRS_CHK(cyc >= 20 && cyc <= 28, 1'b1)
        `FRS_CHK(fl, 0)
        stop("gap");
    endtask
    task automatic t_dly();
        int lo;
        for (i = 0; i < 2; i++) begin
            lo = i ? 40 : 10;
            cfg(f_dly(0, 0, i[0], 1, 10), f_stp(0, 4), f_stp(0, 4),
                f_dev(0, 0, 1), f_dev(0, 0, 1), f_tmr(0, 1), 0, 4);
            nxt(1, 0);
            `FRS_CHK(cyc >= lo && cyc <= lo + 8, 1'b1)
            stop("delay");
        end
    endtask
    task automatic t_once();
        for (i = 0; i < 2; i++) begin
            cfg(0, f_stp(0, 2), f_stp(0, 2), f_dev(0, 0, 1), f_dev(0, 0, 1),
                f_tmr(0, 1), i ? 32'hc00 : 32'h800, 2);
            nxt(1, 0);
            nxt(2, 2);
            if (i == 0) nxt(0, 2);
            repeat (12) @(posedge REF_CLK);
            #1;
            `FRS_CHK(n, BASE + (i ? 37'd2 : 37'd0))
            `FRS_CHK(RAMP_BUSY, 1'b1)
            stop("single burst");
        end
    endtask
    task automatic t_fsk();
        cfg(0, f_stp(0, 4), f_stp(0, 4), f_dev(4, 0, 1), f_dev(5, 2, 100),
            f_tmr(0, 1), 0, 32'hfff);
        repeat (10) @(posedge REF_CLK);
        FSK_DATA <= 1'b1;
        hop();
        `FRS_CHK(n, BASE + 37'd400)
        @(posedge REF_CLK);
        FSK_DATA <= 1'b0;
        hop();
        `FRS_CHK(n, BASE)
        hop();
        `FRS_CHK(n, BASE + 37'd1)
        stop("fsk");
    endtask
    initial begin
        repeat (4) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        #1;
        t_reset();
        t_saw();
        t_tri();
        t_dual();
        t_gap();
        t_dly();
        t_once();
        t_fsk();
        complete_run();
    end
endmodule
